/* File: rtl/cma_backoff.sv */
// Pseudo random slot count for truncated binary exponential backoff
`timescale 1ns/100ps
module cma_backoff #(
  parameter int LIMIT = 10
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] attempt,
  output logic      [9:0] slots
);
  logic [15:0] lfsr_q;

  function automatic logic [9:0] range_mask(input logic [4:0] n);
    logic [4:0] k;
    k = (n > 5'(LIMIT)) ? 5'(LIMIT) : n;
    range_mask = 10'((11'h1 << k) - 11'h1);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= 16'hace1;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // r uniform in 0 .. 2^min(n,10)-1
  assign slots = lfsr_q[9:0] & range_mask(attempt);
endmodule

/* File: rtl/cma_cfg.svh */
// Constants for the CSMA/CD media access block
`ifndef CMA_CFG_SVH
`define CMA_CFG_SVH
`define CMA_OFS_GAP        8'h00
`define CMA_OFS_DEFER      8'h04
`define CMA_OFS_MODE       8'h08
`define CMA_OFS_STATUS     8'h0c
`define CMA_GAP_RST        8'h60
`define CMA_DEFER_PART_ONE_RST       8'h3c
`define CMA_BIT_MODIFIED_BACKOFF_ENABLE       3
`define CMA_BIT_TX2PD      4
`define CMA_BIT_SPEED      0
`define CMA_BIT_RETRY_DISABLE       5
`define CMA_ST_ONE         0
`define CMA_ST_MORE        1
`define CMA_ST_RETRY_FAILURE_FLAG        2
`define CMA_ST_LATE_COLLISION_FLAG        3
`define CMA_ST_DEF         4
`define CMA_PRE_BITS       10'h03f
`define CMA_JAM_BITS       5'h1f
`define CMA_SLOT_BITS      10'h200
`define CMA_SLOT_LAST      9'h1ff
`define CMA_MAX_ATTEMPTS   5'h10
`define CMA_BACKOFF_LIMIT  10
`define CMA_DIV_10M        4'h9
`define CMA_CLK_NS         10
`define CMA_BLIND_NS       4000
`define CMA_BLIND_CYC      (`CMA_BLIND_NS / `CMA_CLK_NS)
`endif

/* File: rtl/cma_mac.sv */
// Half-duplex CSMA/CD media access engine with APB registers
// Functional notes
// - Sensed carrier makes the medium busy; pending frames wait until quiet.
// - Gap timer starts the inter-frame gap when receive carrier drops.
// - After receive the gap splits into a first and second deferral part.
// - In part one, carrier holds the gap count at zero; restart after.
// - In part two with a frame pending, carrier is ignored; transmit anyway.
// - Gap and part-one lengths are programmable; gap resets to 96 bits.
// - Same gap after transmissions and after receptions.
// - Transmit two-part disable ignores part-one length after transmits.
// - Carrier is ignored for 4.0 us after own transmission ends.
// - Carrier from 4 to 6 us after transmit restarts part one only.
// - Collision in preamble: finish 64-bit preamble, then jam.
// - Collision before 512 bits: abort data, send 32-bit zero jam.
// - At most 16 attempts per frame, each retry after random backoff.
// - One/more flags by retry count; 16 collisions sets only retry failure.
// - Retry disable: first collision fails frame, flag failure, flush.
// - Collision after 512 bits is late: jam, flag, flush, no retry.
// - nth retry waits r slots, r random in 0..2^min(n,10)-1.
// - Modified backoff pauses slot and gap counting while carrier sensed.
// - Retry count, deferral and late collision reported per frame.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "cma_cfg.svh"
module cma_mac #(
  parameter int BLIND_CYC = `CMA_BLIND_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        carrier_sense,
  input  wire logic        collision_input,
  input  wire logic        tx_req,
  input  wire logic        tx_done,
  output logic             bit_tick,
  output logic             tx_en,
  output logic             tx_preamble,
  output logic             tx_payload,
  output logic             tx_jam,
  output logic             frame_done,
  output logic             frame_flush
);
  typedef struct packed {
    cma_pkg::cma_state_t  st;
    cma_pkg::cma_cfg_t    cfg;
    cma_pkg::cma_status_t stat;
    logic [3:0]  div;
    logic [7:0]  gap_cnt;
    logic [9:0]  bit_cnt;
    logic [4:0]  jam_cnt;
    logic [4:0]  attempts;
    logic [9:0]  slots;
    logic [8:0]  slot_bits;
    logic [9:0]  blind_cnt;
    logic        col_pend;
    logic        late_pend;
    logic        after_tx;
    logic        deferred;
    logic        done;
    logic        flush;
    logic [31:0] rdata;
  } cma_regs_t;

  cma_regs_t  q;
  cma_regs_t  d;
  logic [9:0] rnd_slots;
  logic       wr_en;
  logic       rd_en;
  logic       tick;
  logic       blind;
  logic       crs_eff;
  logic [7:0] part_one;
  logic       pause;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `CMA_OFS_GAP) || hit(a, `CMA_OFS_DEFER) ||
             hit(a, `CMA_OFS_MODE) || hit(a, `CMA_OFS_STATUS);
  endfunction

  cma_backoff #(
    .LIMIT (`CMA_BACKOFF_LIMIT)
  ) u_backoff (
    .pclk    (pclk),
    .presetn (presetn),
    .attempt (q.attempts),
    .slots   (rnd_slots)
  );

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = q.rdata;

  // Bit-time enable: every cycle at 100 Mbps, every tenth at 10 Mbps
  assign tick    = q.cfg.speed_100 || (q.div == 4'h0);
  assign blind   = (q.blind_cnt != 10'h000);
  assign crs_eff = carrier_sense && !blind;
  assign pause   = q.cfg.modified_backoff_enable && carrier_sense;
  // Part two after our own transmit may be switched off
  assign part_one = (q.after_tx && q.cfg.tx_two_part_defer_disable) ?
                    q.cfg.gap : q.cfg.defer_part_one;

  assign bit_tick    = tick;
  assign tx_preamble = (q.st == cma_pkg::CMA_PRE);
  assign tx_payload  = (q.st == cma_pkg::CMA_DATA);
  assign tx_jam      = (q.st == cma_pkg::CMA_JAM);
  assign tx_en       = tx_preamble || tx_payload || tx_jam;
  assign frame_done  = q.done;
  assign frame_flush = q.flush;

  always_comb begin
    d       = q;
    d.done  = 1'b0;
    d.flush = 1'b0;
    d.div   = (q.div == 4'h0) ? `CMA_DIV_10M : q.div - 4'h1;
    if (blind) begin
      d.blind_cnt = q.blind_cnt - 10'h001;
    end

    // Register writes
    if (wr_en) begin
      if (hit(paddr, `CMA_OFS_GAP)) begin
        d.cfg.gap            = pwdata[7:0];
        d.cfg.defer_part_one = pwdata[15:8];
      end else if (hit(paddr, `CMA_OFS_DEFER)) begin
        d.cfg.modified_backoff_enable   = pwdata[`CMA_BIT_MODIFIED_BACKOFF_ENABLE];
        d.cfg.tx_two_part_defer_disable = pwdata[`CMA_BIT_TX2PD];
      end else if (hit(paddr, `CMA_OFS_MODE)) begin
        d.cfg.retry_disable = pwdata[`CMA_BIT_RETRY_DISABLE];
        d.cfg.speed_100     = pwdata[`CMA_BIT_SPEED];
      end
    end

    // Read data captured in the setup phase
    if (rd_en) begin
      d.rdata = 32'h0;
      if (hit(paddr, `CMA_OFS_GAP)) begin
        d.rdata[15:0] = {q.cfg.defer_part_one, q.cfg.gap};
      end else if (hit(paddr, `CMA_OFS_DEFER)) begin
        d.rdata[`CMA_BIT_MODIFIED_BACKOFF_ENABLE]  = q.cfg.modified_backoff_enable;
        d.rdata[`CMA_BIT_TX2PD] = q.cfg.tx_two_part_defer_disable;
      end else if (hit(paddr, `CMA_OFS_MODE)) begin
        d.rdata[`CMA_BIT_RETRY_DISABLE]  = q.cfg.retry_disable;
        d.rdata[`CMA_BIT_SPEED] = q.cfg.speed_100;
      end else if (hit(paddr, `CMA_OFS_STATUS)) begin
        d.rdata[4:0]  = {q.stat.deferred, q.stat.late_collision_flag,
                         q.stat.retry_failure_flag, q.stat.more, q.stat.one};
        d.rdata[11:8] = q.stat.retries;
        d.rdata[16]   = q.stat.busy;
      end
    end

    case (q.st)
      cma_pkg::CMA_DEFER: begin
        if (crs_eff) begin
          d.after_tx = 1'b0;
        end
        // Carrier in part one, or with nothing pending, restarts the gap
        if (crs_eff && (q.gap_cnt < part_one || !tx_req)) begin
          d.gap_cnt = 8'h00;
          if (tx_req) begin
            d.deferred = 1'b1;
          end
        end else if (tick && !pause && q.gap_cnt < q.cfg.gap) begin
          // Part two with a frame pending does not restart on carrier; modified backoff pauses the count
          d.gap_cnt = q.gap_cnt + 8'h01;
        end
        if (tx_req && q.gap_cnt >= q.cfg.gap) begin
          d.st        = cma_pkg::CMA_PRE;
          d.bit_cnt   = 10'h000;
          d.col_pend  = 1'b0;
          d.late_pend = 1'b0;
          d.attempts  = q.attempts + 5'h01;
          d.stat.busy = 1'b1;
        end
      end

      cma_pkg::CMA_PRE: begin
        if (collision_input) begin
          d.col_pend = 1'b1;
        end
        if (tick) begin
          d.bit_cnt = q.bit_cnt + 10'h001;
          if (q.bit_cnt == `CMA_PRE_BITS) begin
            d.jam_cnt = 5'h00;
            d.st = (q.col_pend || collision_input) ?
                   cma_pkg::CMA_JAM : cma_pkg::CMA_DATA;
          end
        end
      end

      cma_pkg::CMA_DATA: begin
        if (tick && q.bit_cnt != 10'h3ff) begin
          d.bit_cnt = q.bit_cnt + 10'h001;
        end
        if (collision_input) begin
          d.st        = cma_pkg::CMA_JAM;
          d.jam_cnt   = 5'h00;
          d.late_pend = (q.bit_cnt >= `CMA_SLOT_BITS);
        end else if (tx_done) begin
          d.st                       = cma_pkg::CMA_DEFER;
          d.done                     = 1'b1;
          d.stat                     = '0;
          d.stat.busy                = 1'b1;
          d.stat.retries             = 4'(q.attempts - 5'h01);
          d.stat.one                 = (q.attempts == 5'h02);
          d.stat.more                = (q.attempts > 5'h02);
          d.stat.deferred            = q.deferred;
          d.attempts                 = 5'h00;
          d.deferred                 = 1'b0;
          d.gap_cnt                  = 8'h00;
          d.after_tx                 = 1'b1;
          d.blind_cnt                = 10'(BLIND_CYC);
        end
      end

      cma_pkg::CMA_JAM: begin
        if (tick) begin
          d.jam_cnt = q.jam_cnt + 5'h01;
          if (q.jam_cnt == `CMA_JAM_BITS) begin
            d.gap_cnt   = 8'h00;
            d.after_tx  = 1'b1;
            d.blind_cnt = 10'(BLIND_CYC);
            if (q.late_pend || q.cfg.retry_disable ||
                q.attempts >= `CMA_MAX_ATTEMPTS) begin
              // Frame abandoned and removed from the transmit queue
              d.st       = cma_pkg::CMA_DEFER;
              d.done     = 1'b1;
              d.flush    = 1'b1;
              d.stat     = '0;
              d.stat.busy = 1'b1;
              d.stat.late_collision_flag = q.late_pend;
              d.stat.retry_failure_flag  = !q.late_pend;
              d.stat.retries  = 4'(q.attempts - 5'h01);
              d.stat.deferred = q.deferred;
              d.attempts = 5'h00;
              d.deferred = 1'b0;
            end else begin
              d.st        = cma_pkg::CMA_BACKOFF;
              d.slots     = rnd_slots;
              d.slot_bits = 9'h000;
            end
          end
        end
      end

      cma_pkg::CMA_BACKOFF: begin
        if (q.slots == 10'h000) begin
          d.st      = cma_pkg::CMA_DEFER;
          d.gap_cnt = 8'h00;
        end else if (tick && !pause) begin
          d.slot_bits = q.slot_bits + 9'h001;
          if (q.slot_bits == `CMA_SLOT_LAST) begin
            d.slots = q.slots - 10'h001;
          end
        end
      end

      default: begin
        d.st = cma_pkg::CMA_DEFER;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                    <= '0;
      q.st                 <= cma_pkg::CMA_DEFER;
      q.cfg.gap            <= `CMA_GAP_RST;
      q.cfg.defer_part_one <= `CMA_DEFER_PART_ONE_RST;
    end else begin
      q <= d;
    end
  end
endmodule

/* File: rtl/cma_pkg.sv */
// Types for the CSMA/CD media access block
package cma_pkg;
  typedef enum logic [2:0] {
    CMA_DEFER   = 3'h0,
    CMA_PRE     = 3'h1,
    CMA_DATA    = 3'h3,
    CMA_JAM     = 3'h2,
    CMA_BACKOFF = 3'h6
  } cma_state_t;

  typedef struct packed {
    logic       busy;
    logic [3:0] retries;
    logic       deferred;
    logic       late_collision_flag;
    logic       retry_failure_flag;
    logic       more;
    logic       one;
  } cma_status_t;

  typedef struct packed {
    logic [7:0] gap;
    logic [7:0] defer_part_one;
    logic       modified_backoff_enable;
    logic       tx_two_part_defer_disable;
    logic       retry_disable;
    logic       speed_100;
  } cma_cfg_t;
endpackage

/* File: tb/cma_mac_assertions.sv */
// Port checks for the media access engine
`timescale 1ns/100ps
module cma_mac_assertions #(
  parameter int BLIND_CYC = 400
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic collision_input,
  input wire logic tx_done,
  input wire logic bit_tick,
  input wire logic tx_en,
  input wire logic tx_preamble,
  input wire logic tx_payload,
  input wire logic tx_jam,
  input wire logic frame_done,
  input wire logic frame_flush
);
  logic [6:0]  pre_q;
  logic [5:0]  jam_q;
  logic [10:0] bits_q;
  logic        pcol_q;
  logic        late_q;
  // Bit counts per phase and collision history of the current attempt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= 7'h00;
      jam_q  <= 6'h00;
      bits_q <= 11'h000;
      pcol_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      pre_q  <= tx_preamble ? pre_q + 7'(bit_tick) : 7'h00;
      jam_q  <= tx_jam ? jam_q + 6'(bit_tick) : 6'h00;
      bits_q <= tx_en ? bits_q + 11'(bit_tick) : 11'h000;
      pcol_q <= tx_preamble & (pcol_q | collision_input);
      late_q <= ~tx_preamble & (late_q | (tx_payload & collision_input & (bits_q > 11'h208)));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_jam_next; ##1 tx_jam; endsequence
  sequence s_drop_done; ##[0:2] (frame_done && frame_flush); endsequence
  chk_pre_len: assert property ($fell(tx_preamble) |-> pre_q == 7'h40)
    else $error("preamble length wrong");
  chk_pre_next: assert property ($fell(tx_preamble) |-> (pcol_q ? tx_jam : tx_payload))
    else $error("wrong phase after preamble");
  chk_jam_len: assert property ($fell(tx_jam) |-> jam_q == 6'h20)
    else $error("jam length wrong");
  chk_payload_jam: assert property (tx_payload && collision_input |-> s_jam_next)
    else $error("no jam after collision");
  chk_late_drop: assert property ($fell(tx_jam) && late_q |-> s_drop_done)
    else $error("late collision not dropped");
  chk_flush_done: assert property (frame_flush |-> frame_done)
    else $error("flush without done");
  chk_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("done longer than one cycle");
  chk_done_end: assert property (tx_payload && tx_done && !collision_input |=> !tx_en && frame_done)
    else $error("frame did not end");
endmodule
bind cma_mac cma_mac_assertions #(.BLIND_CYC(BLIND_CYC)) cma_mac_assertions_inst (
  .pclk, .presetn, .collision_input, .tx_done, .bit_tick, .tx_en, .tx_preamble,
  .tx_payload, .tx_jam, .frame_done, .frame_flush
);

/* File: tb/cma_phy_model.sv */
// Behavioural transceiver: carrier echo, receive bursts and collisions
`timescale 1ns/100ps
module cma_phy_model (
  input  wire logic pclk,
  input  wire logic tx_en,
  output logic      carrier_sense,
  output logic      collision_input = 1'b0
);
  int   col_left = 0;
  int   col_at   = 0;
  int   t_q      = 0;
  logic rx_q     = 1'b0;
  logic echo_q   = 1'b0;
  logic hit_q    = 1'b0;
  assign carrier_sense = rx_q | echo_q;
  always @(posedge pclk) begin
    echo_q          <= tx_en;
    t_q             <= tx_en ? t_q + 1 : 0;
    hit_q           <= tx_en & (hit_q | collision_input);
    collision_input <= tx_en && col_left > 0 && t_q >= col_at;
    if (echo_q && !tx_en && hit_q) begin
      col_left <= col_left - 1;
    end
  end
  task automatic collide(input int n, input int at);
    col_left = n;
    col_at   = at;
  endtask
  task automatic receive(input int n);
    rx_q <= 1'b1;
    repeat (n) @(posedge pclk);
    rx_q <= 1'b0;
  endtask
endmodule

/* File: tb/csma_cd_media_access_tb.sv */
// Self-checking bench for the media access engine
`timescale 1ns/100ps
module csma_cd_media_access_tb;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        tx_req     = 1'b0;
  logic        tx_done    = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, carrier_sense, collision_input, bit_tick, tx_en;
  logic        tx_preamble, tx_payload, tx_jam, frame_done, frame_flush, er;
  logic [31:0] rd;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          plen       = 100;
  int          pc         = 0;
  always #5 pclk = ~pclk;
  cma_mac #(.BLIND_CYC(20)) cma_mac_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .carrier_sense, .collision_input, .tx_req, .tx_done, .bit_tick, .tx_en, .tx_preamble,
    .tx_payload, .tx_jam, .frame_done, .frame_flush
  );
  cma_phy_model cma_phy_model_inst (.pclk, .tx_en, .carrier_sense, .collision_input);
  // Framer: ends the payload after plen cycles
  always @(posedge pclk) begin
    pc      <= tx_payload ? pc + 1 : 0;
    tx_done <= tx_payload && pc == plen;
    cyc     <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      finish_test;
    end
  end
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_end(input logic [31:0] exp, input logic [31:0] msk, input logic fl);
    int k;
    k = 0;
    do begin @(negedge pclk); k++; end while (frame_done !== 1'b1 && k < 20000);
    chk({30'h0, frame_done, frame_flush}, {30'h0, 1'b1, fl}, "frame end");
    @(posedge pclk);
    tx_req <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd & msk, exp, "status");
  endtask
  task automatic frame(input int n, input int at, input int len, input logic [31:0] exp,
                       input logic [31:0] msk, input logic fl);
    cma_phy_model_inst.collide(n, at);
    plen = len;
    @(posedge pclk);
    tx_req <= 1'b1;
    wait_end(exp, msk, fl);
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3c60, "gap reset");
    apb(1'b1, 8'h00, 32'h3c40);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3c40, "gap write");
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped");
    apb(1'b1, 8'h04, 32'h18);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h18, "defer control");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h1);
  endtask
  task automatic t_gap;
    int n;
    n = 0;
    fork
      cma_phy_model_inst.receive(60);
    join_none
    repeat (10) @(posedge pclk);
    tx_req <= 1'b1;
    @(negedge pclk);
    while (carrier_sense === 1'b1) begin
      if (tx_en !== 1'b0) n++;
      @(negedge pclk);
    end
    chk(n, 0, "deferral");
    n = 0;
    while (tx_preamble !== 1'b1 && n < 500) begin @(negedge pclk); n++; end
    chk(n >= 64 && n <= 68, 1, "gap length");
    wait_end(32'h0, 32'h0f0f, 1'b0);
  endtask
  task automatic t_clean;
    frame(0, 0, 100, 32'h0, 32'h0f0f, 1'b0);
  endtask
  task automatic t_one;
    frame(1, 80, 100, 32'h0101, 32'h0f0f, 1'b0);
  endtask
  task automatic t_two;
    frame(2, 80, 100, 32'h0202, 32'h0f0f, 1'b0);
  endtask
  task automatic t_noretry;
    apb(1'b1, 8'h08, 32'h21);
    frame(1, 20, 100, 32'h4, 32'hf, 1'b1);
    apb(1'b1, 8'h08, 32'h1);
  endtask
  task automatic t_late;
    frame(1, 700, 1000, 32'h8, 32'hf, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_clean;
    t_gap;
    t_one;
    t_two;
    t_noretry;
    t_late;
    finish_test;
  end
endmodule
